//--- logic/rsse_pkg.sv
package rsse_pkg;
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_INSTR = 6'h04;
	localparam logic [5:0] OFS_STATUS = 6'h08;
	localparam logic [5:0] OFS_WREG = 6'h0c;
	localparam logic [5:0] OFS_BANK = 6'h10;
	localparam logic [5:0] OFS_IDX_BASE = 6'h14;
	localparam logic [5:0] OFS_MEM_ADDR = 6'h18;
	localparam logic [5:0] OFS_MEM_DATA = 6'h1c;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h20;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h24;
	localparam logic [5:0] OFS_WDOG = 6'h28;

	localparam int CTRL_EXT_BIT = 0;
	localparam int ST_NEG_BIT = 0;
	localparam int ST_ZERO_BIT = 1;
	localparam int ST_TO_BIT = 2;
	localparam int ST_PD_BIT = 3;
	localparam int ST_SLEEP_BIT = 4;
	localparam int ST_BUSY_BIT = 5;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_SLEEP_BIT = 1;
	localparam int IRQ_WAKE_BIT = 2;
	localparam int IRQ_W = 3;
	localparam int WDOG_POST_LSB = 8;

	localparam logic [5:0] OP_ROT_HI = 6'b010000;
	localparam logic [6:0] OP_SET_HI = 7'b0110100;
	localparam logic [15:0] OP_SLEEP = 16'h0003;
	localparam logic [7:0] INDEXED_MAX = 8'h5f;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] WDOG_CLEAR = 8'h00;

	localparam logic RST_TIMEOUT = 1'b1;
	localparam logic RST_POWERDOWN = 1'b1;
	localparam logic [7:0] RST_WREG = 8'h00;
	localparam logic [3:0] RST_BANK = 4'h0;

	typedef enum {K_NOP, K_ROT, K_SET, K_SLEEP} rsse_kind_e;
endpackage

//--- logic/rsse_dec_if.sv
`timescale 1ns/1ns
interface rsse_dec_if;
	import rsse_pkg::*;
	logic [15:0] instr;
	rsse_kind_e kind;
	logic dest_file;
	logic access_bsr;
	logic [7:0] f;
	logic [3:0] bank_select_reg;
	logic ext_en;
	logic [11:0] idx_base;
	logic [11:0] addr;
	modport dec (input instr, output kind, dest_file, access_bsr, f);
	modport agen (input access_bsr, f, bank_select_reg, ext_en, idx_base, output addr);
	modport core (output instr, bank_select_reg, ext_en, idx_base,
		input kind, dest_file, access_bsr, f, addr);
endinterface

//--- logic/rsse_decode.sv
`timescale 1ns/1ns
module rsse_decode
	import rsse_pkg::*;
(
	rsse_dec_if.dec dif
);
	always_comb begin
		dif.f = dif.instr[7:0];
		dif.access_bsr = dif.instr[8];
		dif.dest_file = dif.instr[9];
		if (dif.instr[15:10] == OP_ROT_HI) begin
			dif.kind = K_ROT;
		end else if (dif.instr[15:9] == OP_SET_HI) begin
			dif.kind = K_SET;
			dif.dest_file = 1'b1;
		end else if (dif.instr == OP_SLEEP) begin
			dif.kind = K_SLEEP;
		end else begin
			dif.kind = K_NOP;
		end
	end
endmodule

//--- logic/rsse_addr_gen.sv
`timescale 1ns/1ns
module rsse_addr_gen
	import rsse_pkg::*;
(
	rsse_dec_if.agen aif
);
	logic low_half;
	assign low_half = (aif.f <= INDEXED_MAX);
	always_comb begin
		if (aif.access_bsr) begin
			aif.addr = {aif.bank_select_reg, aif.f};
		end else if (aif.ext_en && low_half) begin
			// Index base wraps within the data space
			aif.addr = 12'(aif.idx_base + {4'h0, aif.f});
		end else if (low_half) begin
			aif.addr = {4'h0, aif.f};
		end else begin
			aif.addr = {ACCESS_HI_BANK, aif.f};
		end
	end
endmodule

//--- logic/rsse_core.sv
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module rsse_core
	import rsse_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int POST_W = 4
)
(
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_irq,
	input wire logic i_wdt_tick,
	input wire logic i_wake,
	output logic o_sleeping
);
	typedef enum {S_IDLE, S_Q1, S_Q2, S_Q3, S_Q4, S_SLEEP} rsse_state_e;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] rot_right(input logic [7:0] v);
		return {v[0], v[7:1]};
	endfunction

	rsse_dec_if dif();
	rsse_decode u_dec (.dif(dif));
	rsse_addr_gen u_agen (.aif(dif));

	rsse_state_e state_r;
	logic [15:0] instr_r;
	logic ext_en_r;
	logic [7:0] w_r;
	logic [3:0] bsr_r;
	logic [11:0] idx_base_r;
	logic [11:0] mem_addr_r;
	logic [7:0] file_mem [0:2**ADDR_W-1];
	rsse_kind_e op_kind_r;
	logic op_d_r;
	logic op_a_r;
	logic [7:0] op_f_r;
	logic [11:0] addr_r;
	logic [7:0] opnd_r;
	logic [7:0] result_r;
	logic neg_r;
	logic zero_r;
	logic timeout_flag_r;
	logic powerdown_flag_r;
	logic [7:0] watchdog_counter_r;
	logic [POST_W-1:0] wdt_post_r;
	logic wake_s1_r;
	logic wake_s2_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic rvalid_r;
	logic [31:0] readdata_r;
	logic [31:0] rd_mux;
	logic busy;
	logic wr_acc;
	logic rd_acc;
	logic wdt_timeout;
	logic wake_any;
	logic [31:0] wr_word;
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;
	logic [7:0] rot_exp;

	assign dif.instr = instr_r;
	assign dif.bank_select_reg = bsr_r;
	assign dif.ext_en = ext_en_r;
	assign dif.idx_base = idx_base_r;

	// Avalon slave: every write stalls while an instruction or sleep is active
	assign busy = (state_r != S_IDLE);
	assign o_waitrequest = (i_read & ~rvalid_r) | (i_write & busy);
	assign wr_acc = i_write & ~busy;
	assign rd_acc = i_read & rvalid_r;
	assign o_readdata = readdata_r;
	assign o_sleeping = (state_r == S_SLEEP);
	assign wr_word = merge(32'h0000_0000, i_writedata, i_byteenable);
	assign rot_exp = rot_right(opnd_r);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_address)
			OFS_CTRL: rd_mux[CTRL_EXT_BIT] = ext_en_r;
			OFS_INSTR: rd_mux[15:0] = instr_r;
			OFS_STATUS: begin
				rd_mux[ST_NEG_BIT] = neg_r;
				rd_mux[ST_ZERO_BIT] = zero_r;
				rd_mux[ST_TO_BIT] = timeout_flag_r;
				rd_mux[ST_PD_BIT] = powerdown_flag_r;
				rd_mux[ST_SLEEP_BIT] = o_sleeping;
				rd_mux[ST_BUSY_BIT] = busy;
			end
			OFS_WREG: rd_mux[7:0] = w_r;
			OFS_BANK: rd_mux[3:0] = bsr_r;
			OFS_IDX_BASE: rd_mux[11:0] = idx_base_r;
			OFS_MEM_ADDR: rd_mux[11:0] = mem_addr_r;
			OFS_MEM_DATA: rd_mux[7:0] = file_mem[mem_addr_r[ADDR_W-1:0]];
			OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
			OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
			OFS_WDOG: begin
				rd_mux[7:0] = watchdog_counter_r;
				rd_mux[WDOG_POST_LSB +: POST_W] = wdt_post_r;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// One wait state gives the file memory a full cycle before data leave
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			rvalid_r <= 1'b0;
			readdata_r <= 32'h0000_0000;
		end else begin
			rvalid_r <= i_read & ~rvalid_r;
			if (i_read & ~rvalid_r) begin
				readdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			ext_en_r <= 1'b0;
			instr_r <= 16'h0000;
			bsr_r <= RST_BANK;
			idx_base_r <= 12'h000;
			mem_addr_r <= 12'h000;
			irq_mask_r <= '0;
		end else if (wr_acc) begin
			case (i_address)
				OFS_CTRL: ext_en_r <= wr_word[CTRL_EXT_BIT];
				OFS_INSTR: instr_r <= wr_word[15:0];
				OFS_BANK: bsr_r <= wr_word[3:0];
				OFS_IDX_BASE: idx_base_r <= wr_word[11:0];
				OFS_MEM_ADDR: mem_addr_r <= wr_word[11:0];
				OFS_IRQ_MASK: irq_mask_r <= wr_word[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Phase sequencer; a write to the instruction register issues it
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			state_r <= S_IDLE;
		end else begin
			case (state_r)
				S_IDLE: if (wr_acc && i_address == OFS_INSTR) begin
					state_r <= S_Q1;
				end
				S_Q1: state_r <= S_Q2;
				S_Q2: state_r <= S_Q3;
				S_Q3: state_r <= S_Q4;
				S_Q4: state_r <= (op_kind_r == K_SLEEP) ? S_SLEEP : S_IDLE;
				S_SLEEP: if (wake_any) begin
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Q1 latches the decode so later writes cannot disturb it
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			op_kind_r <= K_NOP;
			op_d_r <= 1'b1;
			op_a_r <= 1'b1;
			op_f_r <= 8'h00;
			addr_r <= 12'h000;
		end else if (state_r == S_Q1) begin
			op_kind_r <= dif.kind;
			op_d_r <= dif.dest_file;
			op_a_r <= dif.access_bsr;
			op_f_r <= dif.f;
			addr_r <= dif.addr;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			opnd_r <= 8'h00;
			result_r <= 8'h00;
		end else begin
			if (state_r == S_Q2) begin
				opnd_r <= file_mem[addr_r[ADDR_W-1:0]];
			end
			if (state_r == S_Q3) begin
				result_r <= (op_kind_r == K_SET) ? ALL_ONES : rot_exp;
			end
		end
	end

	// Memory has no reset; bus and core writes never meet since busy stalls
	always_ff @(posedge i_mclk) begin
		if (state_r == S_Q4 && op_d_r &&
			(op_kind_r == K_ROT || op_kind_r == K_SET)) begin
			file_mem[addr_r[ADDR_W-1:0]] <= result_r;
		end else if (wr_acc && i_address == OFS_MEM_DATA && i_byteenable[0]) begin
			file_mem[mem_addr_r[ADDR_W-1:0]] <= i_writedata[7:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			w_r <= RST_WREG;
		end else if (state_r == S_Q4 && op_kind_r == K_ROT && !op_d_r) begin
			w_r <= result_r;
		end else if (wr_acc && i_address == OFS_WREG && i_byteenable[0]) begin
			w_r <= i_writedata[7:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			neg_r <= 1'b0;
			zero_r <= 1'b0;
		end else if (state_r == S_Q4 && op_kind_r == K_ROT) begin
			neg_r <= result_r[7];
			zero_r <= (result_r == 8'h00);
		end
	end

	// Watchdog counter with postscaler; times out when both wrap together
	assign wdt_timeout = i_wdt_tick && (watchdog_counter_r == 8'hff) &&
		(&wdt_post_r);
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			watchdog_counter_r <= WDOG_CLEAR;
			wdt_post_r <= '0;
		end else if (state_r == S_Q4 && op_kind_r == K_SLEEP) begin
			watchdog_counter_r <= WDOG_CLEAR;
			wdt_post_r <= '0;
		end else if (i_wdt_tick) begin
			watchdog_counter_r <= 8'(watchdog_counter_r + 8'h01);
			if (watchdog_counter_r == 8'hff) begin
				wdt_post_r <= POST_W'(wdt_post_r + 1'b1);
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			wake_s1_r <= 1'b0;
			wake_s2_r <= 1'b0;
		end else begin
			wake_s1_r <= i_wake;
			wake_s2_r <= wake_s1_r;
		end
	end
	// Watchdog and pin wakes are ORed; the time-out flag follows the watchdog alone, so a time-out is reported whenever it ends a sleep
	assign wake_any = wake_s2_r | wdt_timeout;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			timeout_flag_r <= RST_TIMEOUT;
			powerdown_flag_r <= RST_POWERDOWN;
		end else if (state_r == S_Q4 && op_kind_r == K_SLEEP) begin
			timeout_flag_r <= 1'b1;
			powerdown_flag_r <= 1'b0;
		end else if (state_r == S_SLEEP && wdt_timeout) begin
			timeout_flag_r <= 1'b0;
		end
	end

	assign irq_ev[IRQ_DONE_BIT] = (state_r == S_Q4) && (op_kind_r != K_SLEEP);
	assign irq_ev[IRQ_SLEEP_BIT] = (state_r == S_Q4) && (op_kind_r == K_SLEEP);
	assign irq_ev[IRQ_WAKE_BIT] = (state_r == S_SLEEP) && wake_any;
	// Clear only the bits the read returned, so a late event is not lost
	assign irq_clr = (rd_acc && i_address == OFS_IRQ_STAT) ?
		readdata_r[IRQ_W-1:0] : '0;
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
		end
	end
	assign o_irq = |(irq_stat_r & irq_mask_r);

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	chk_rot_to_file: assert property (
		state_r == S_Q4 && op_kind_r == K_ROT && op_d_r |=>
		file_mem[$past(addr_r[ADDR_W-1:0])] == $past(rot_exp))
		else $error("rotate result not written to file register");
	chk_rot_to_w: assert property (
		state_r == S_Q4 && op_kind_r == K_ROT && !op_d_r |=>
		w_r == $past(rot_exp) &&
		file_mem[$past(addr_r[ADDR_W-1:0])] == $past(opnd_r))
		else $error("rotate to accumulator wrong or file register changed");
	chk_rot_flags: assert property (
		state_r == S_Q4 && op_kind_r == K_ROT |=>
		neg_r == $past(rot_exp[7]) && zero_r == ($past(rot_exp) == 8'h00))
		else $error("rotate flags wrong");
	chk_set_all_ones: assert property (
		state_r == S_Q4 && op_kind_r == K_SET |=>
		file_mem[$past(addr_r[ADDR_W-1:0])] == ALL_ONES &&
		$stable(neg_r) && $stable(zero_r))
		else $error("set-all-ones wrote wrong value or touched flags");
	chk_bank_select: assert property (
		state_r == S_Q2 && op_a_r |-> addr_r == {bsr_r, op_f_r})
		else $error("bank select address wrong");
	chk_indexed_mode: assert property (
		state_r == S_Q2 && !op_a_r && ext_en_r && op_f_r <= INDEXED_MAX |->
		addr_r == 12'(idx_base_r + {4'h0, op_f_r}))
		else $error("indexed literal offset address wrong");
	chk_sleep_entry: assert property (
		state_r == S_Q4 && op_kind_r == K_SLEEP |=>
		timeout_flag_r && !powerdown_flag_r && state_r == S_SLEEP &&
		watchdog_counter_r == WDOG_CLEAR && wdt_post_r == '0)
		else $error("sleep entry side effects wrong");
	chk_sleep_hold: assert property (
		state_r == S_SLEEP && !wake_any |=> state_r == S_SLEEP)
		else $error("left sleep without a wake-up");
	chk_wdt_wake: assert property (
		state_r == S_SLEEP && wdt_timeout |=>
		!timeout_flag_r && state_r == S_IDLE)
		else $error("watchdog wake did not clear time-out flag");
	chk_phase_order: assert property (
		state_r == S_Q1 |=> state_r == S_Q2 ##1 state_r == S_Q3
		##1 state_r == S_Q4)
		else $error("phase sequence broken");

	cov_rot_w: cover property (state_r == S_Q4 && op_kind_r == K_ROT && !op_d_r);
	cov_set: cover property (state_r == S_Q4 && op_kind_r == K_SET);
	cov_pin_wake: cover property (state_r == S_SLEEP && wake_s2_r ##1
		state_r == S_IDLE);
	cov_wdt_wake: cover property (state_r == S_SLEEP && wdt_timeout);
endmodule

//--- bench/rsse_core_tb.sv
`timescale 1ns/1ns
module rsse_core_tb;
	import rsse_pkg::*;
	logic i_mclk, i_nrst, i_read, i_write, i_wdt_tick, i_wake;
	logic [5:0] i_address;
	logic [31:0] i_writedata, o_readdata, rd;
	logic [3:0] i_byteenable;
	logic o_waitrequest, o_irq, o_sleeping;
	logic [15:0] op;
	int n_fail, checked, seed, waits, ticks;
	int bank, ext, idx, w, n, z, to, pd, kind, d, a, f, v, adr, r;

	rsse_core #(.ADDR_W(12), .POST_W(1)) uut (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_address(i_address),
		.i_read(i_read),
		.i_write(i_write),
		.i_writedata(i_writedata),
		.i_byteenable(i_byteenable),
		.o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest),
		.o_irq(o_irq),
		.i_wdt_tick(i_wdt_tick),
		.i_wake(i_wake),
		.o_sleeping(o_sleeping)
	);

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request is left standing on return; the next call or idle replaces it
	task automatic bus_wait();
		waits = 0;
		@(posedge i_mclk);
		while (o_waitrequest !== 1'b0 && waits < 5000) begin
			waits++;
			@(posedge i_mclk);
		end
	endtask

	task automatic bus_wr(input logic [5:0] ad, input logic [31:0] dt);
		i_address <= ad;
		i_writedata <= dt;
		i_read <= 1'b0;
		i_write <= 1'b1;
		bus_wait();
	endtask

	task automatic bus_rd(input logic [5:0] ad);
		i_address <= ad;
		i_write <= 1'b0;
		i_read <= 1'b1;
		bus_wait();
		rd = o_readdata;
	endtask

	task automatic idle(input int k);
		i_read <= 1'b0;
		i_write <= 1'b0;
		repeat (k) @(posedge i_mclk);
	endtask

	task automatic look(input logic got, input logic exp);
		@(negedge i_mclk);
		chk({31'h0, got}, {31'h0, exp});
		@(posedge i_mclk);
	endtask

	task automatic tick();
		i_wdt_tick <= 1'b1;
		@(posedge i_mclk);
		i_wdt_tick <= 1'b0;
		@(posedge i_mclk);
	endtask

	function automatic int ea(int aa, int ff);
		if (aa == 1) return bank * 256 + ff;
		if (ff > 95) return 3840 + ff;
		if (ext == 1) return (idx + ff) % 4096;
		return ff;
	endfunction

	// Busy reads high for all of sleep, so it rises with the sleep bit
	function automatic logic [31:0] st(int sl);
		return 32'(sl * 48 + pd * 8 + to * 4 + z * 2 + n);
	endfunction

	initial begin
		#200000;
		n_fail++;
		end_sim();
	end

	initial begin
		seed = 74481;
		i_nrst = 1'b0;
		i_read = 1'b0;
		i_write = 1'b0;
		i_address = 6'h00;
		i_writedata = 32'h0;
		i_byteenable = 4'hf;
		i_wdt_tick = 1'b0;
		i_wake = 1'b0;
		to = 1;
		pd = 1;
		n = 0;
		z = 0;
		repeat (8) @(posedge i_mclk);
		i_nrst <= 1'b1;
		@(posedge i_mclk);
		bus_rd(OFS_STATUS);
		chk(rd & 32'h3c, 32'h0c);
		bus_wr(6'h3c, 32'h5a5a);
		bus_rd(6'h3c);
		chk(rd, 32'h0);
		for (int i = 0; i < 24; i++) begin
			kind = (i == 0) ? 0 : ($random(seed) & 1);
			d = $random(seed) & 1;
			a = $random(seed) & 1;
			f = $random(seed) & 255;
			// Straddle the indexed window edge first
			if (i < 4) begin
				f = 95 + (i & 1);
				a = 0;
			end
			bank = $random(seed) & 15;
			ext = (i < 2) ? 1 : ($random(seed) & 1);
			idx = $random(seed) & 4095;
			w = $random(seed) & 255;
			v = $random(seed) & 255;
			bus_wr(OFS_CTRL, ext);
			bus_wr(OFS_BANK, bank);
			bus_wr(OFS_IDX_BASE, idx);
			bus_wr(OFS_WREG, w);
			adr = ea(a, f);
			bus_wr(OFS_MEM_ADDR, adr);
			bus_wr(OFS_MEM_DATA, v);
			if (kind == 1) op = {OP_SET_HI, a[0], f[7:0]};
			else op = {OP_ROT_HI, d[0], a[0], f[7:0]};
			bus_wr(OFS_INSTR, {16'h0, op});
			bus_wr(OFS_MEM_ADDR, adr);
			chk(waits, 4);
			r = (v >> 1) | ((v & 1) << 7);
			if (kind == 1) begin
				v = 255;
			end else begin
				n = r >> 7;
				z = (r == 0) ? 1 : 0;
				if (d == 1) v = r;
				else w = r;
			end
			bus_rd(OFS_MEM_DATA);
			chk(rd, v);
			bus_rd(OFS_WREG);
			chk(rd, w);
			bus_rd(OFS_STATUS);
			chk(rd, st(0));
		end
		bus_wr(OFS_IRQ_MASK, 0);
		bus_rd(OFS_IRQ_STAT);
		bus_wr(OFS_INSTR, 0);
		idle(6);
		look(o_irq, 1'b0);
		bus_wr(OFS_IRQ_MASK, 1);
		idle(1);
		look(o_irq, 1'b1);
		bus_rd(OFS_IRQ_STAT);
		chk(rd, 1);
		idle(1);
		look(o_irq, 1'b0);
		repeat (5) tick();
		bus_rd(OFS_WDOG);
		chk(rd, 5);
		bus_wr(OFS_INSTR, OP_SLEEP);
		to = 1;
		pd = 0;
		idle(6);
		look(o_sleeping, 1'b1);
		bus_rd(OFS_STATUS);
		chk(rd, st(1));
		bus_rd(OFS_WDOG);
		chk(rd, 0);
		idle(20);
		look(o_sleeping, 1'b1);
		bus_rd(OFS_IRQ_STAT);
		chk(rd, 2);
		// A read left standing would clear the wake bit before it is seen
		i_read <= 1'b0;
		i_wake <= 1'b1;
		ticks = 0;
		while (o_sleeping !== 1'b0 && ticks < 20) begin
			@(posedge i_mclk);
			ticks++;
		end
		chk(ticks < 20, 1);
		i_wake <= 1'b0;
		bus_rd(OFS_STATUS);
		chk(rd, st(0));
		bus_rd(OFS_IRQ_STAT);
		chk(rd, 4);
		bus_wr(OFS_INSTR, OP_SLEEP);
		idle(6);
		ticks = 0;
		// Extra edge per tick leaves room for the wake to land
		while (o_sleeping === 1'b1 && ticks < 2000) begin
			tick();
			@(posedge i_mclk);
			ticks++;
		end
		chk(ticks, 512);
		to = 0;
		bus_rd(OFS_STATUS);
		chk(rd, st(0));
		bus_rd(OFS_IRQ_STAT);
		chk(rd, 6);
		idle(2);
		end_sim();
	end
endmodule
